// File: core/ict_pkg.sv
/*
 shared constants and carrier types of the instruction cycle timing block.
 assumes nothing beyond a systemverilog compiler.
*/
package ict_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // one machine period is four crystal periods
    localparam int unsigned XTAL_PER_MACHINE = 4;
    localparam logic [3:0] WAIT_W = 4'h4;
    localparam logic [15:0] REPEAT_RESET = 16'h0001;
    localparam logic [3:0] WAIT_MAX = 4'hf;

    // memory location of a fetch or operand
    typedef enum logic [1:0] {
        ICT_LOC_RAM = 2'b00,
        ICT_LOC_ROM = 2'b01,
        ICT_LOC_EXT = 2'b10
    } ict_loc_t;

    // cycle classes that this block times
    typedef enum logic [3:0] {
        ICT_CLS_LOAD = 4'h1,
        ICT_CLS_STORE = 4'h3,
        ICT_CLS_SIMPLE = 4'h4,
        ICT_CLS_LONG_IMM = 4'h5,
        ICT_CLS_COND_BR = 4'h7,
        ICT_CLS_UNCOND_BR = 4'h8,
        ICT_CLS_PORT_RD = 4'h9,
        ICT_CLS_PORT_WR = 4'ha,
        ICT_CLS_TBL_RD = 4'hb,
        ICT_CLS_TBL_WR = 4'hc
    } ict_cls_t;

    // one instruction to be timed
    typedef struct packed {
        ict_cls_t cls;
        ict_loc_t code_loc;
        logic data_ext;
        logic tbl_in_rom;
        logic repeat_on;
        logic [15:0] repeat_n;
    } ict_req_t;

    // answer: cycle count and refusal flags
    typedef struct packed {
        logic [31:0] cycles;
        logic not_repeatable;
        logic unsupported;
    } ict_ans_t;

    typedef enum logic [0:0] {
        ICT_ST_IDLE = 1'b0,
        ICT_ST_DONE = 1'b1
    } ict_state_t;
endpackage : ict_pkg

// File: core/ict_wait_calc.sv
/*
 converts a memory access time into a wait-state count.
 assumes access and limit times in ns and a constant machine period in ns.
*/
`timescale 1ns/100ps
`default_nettype none
module ict_wait_calc
    import ict_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [15:0] t_mem_ns,
    input wire logic [15:0] t_ac_ns,
    input wire logic [15:0] t_machine_ns,
    output logic [3:0] waits
);
    typedef struct packed {
        logic [3:0] waits;
    } ict_wc_state_t;

    ict_wc_state_t s_q, s_d;
    logic [3:0] k;

    // smallest k with t_mem <= k*t_machine + t_ac, saturating at WAIT_MAX
    always_comb begin
        logic [31:0] bound;
        bound = 32'h0;
        k = WAIT_MAX;
        for (int j = int'(WAIT_MAX); j >= 0; j--) begin
            bound = 32'(j) * 32'(t_machine_ns) + 32'(t_ac_ns);
            if (32'(t_mem_ns) <= bound) begin
                k = 4'(j);
            end
        end
        s_d = s_q;
        s_d.waits = k;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign waits = s_q.waits;
endmodule // ict_wait_calc
`default_nettype wire

// File: core/ict_cycle_table.sv
/*
 combinational cycle formula per class and location, with registered result.
 assumes wait counts and repeat count are stable while a request is taken.
*/
`timescale 1ns/100ps
`default_nettype none
module ict_cycle_table
    import ict_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic load,
    input wire ict_req_t req,
    input wire logic [3:0] p,
    input wire logic [3:0] d,
    input wire logic [3:0] i,
    output ict_ans_t ans
);
    typedef struct packed {
        ict_ans_t ans;
    } ict_ct_state_t;

    ict_ct_state_t s_q, s_d;

    always_comb begin
        logic [31:0] n, pp, dd, ii, c;
        logic ext_code, ext_data, rep_bad, unsup;
        n = 32'(req.repeat_n);
        ext_code = (req.code_loc == ICT_LOC_EXT);
        ext_data = req.data_ext;
        // waits only count where the access goes off chip
        pp = ext_code ? 32'(p) : 32'h0;
        dd = ext_data ? 32'(d) : 32'h0;
        ii = 32'(i);
        c = 32'h1;
        rep_bad = 1'b0;
        unsup = 1'b0;
        case (req.cls)
            ICT_CLS_LOAD: begin
                if (req.repeat_on) begin
                    c = n + n * dd + pp + ((ext_data) ? 32'h1 : 32'h0);
                end else begin
                    c = 32'h1 + dd + pp + ((ext_data) ? 32'h1 : 32'h0);
                end
            end
            ICT_CLS_STORE: begin
                c = 32'h1 + dd + pp + ((ext_data && ext_code) ? 32'h1 : 32'h0);
            end
            ICT_CLS_PORT_RD: begin
                if (req.repeat_on && !ext_code && ext_data) begin
                    c = 32'h2 * n + n * dd + n * ii;
                end else if (req.repeat_on) begin
                    c = 32'h1 + n + pp + n * ii;
                end else begin
                    c = 32'h2 + dd + pp + ii + ((ext_data && ext_code) ? 32'h1 : 32'h0);
                end
            end
            ICT_CLS_PORT_WR: begin
                c = 32'h1 + dd + pp + ii
                    + ((ext_data || ext_code) ? 32'h1 : 32'h0)
                    + ((ext_data && ext_code) ? 32'h1 : 32'h0);
            end
            ICT_CLS_LONG_IMM: begin
                rep_bad = req.repeat_on;
                c = 32'h2 + pp + pp;
            end
            ICT_CLS_COND_BR: begin
                rep_bad = req.repeat_on;
                c = 32'h2 + pp + pp;
            end
            ICT_CLS_UNCOND_BR: begin
                rep_bad = req.repeat_on;
                c = 32'h2 + pp;
            end
            ICT_CLS_TBL_WR: begin
                unsup = req.tbl_in_rom;
                c = unsup ? 32'h0 : 32'h2 + pp + dd;
            end
            default: begin
                c = req.repeat_on ? n + pp : 32'h1 + pp;
            end
        endcase
        if (rep_bad) begin
            c = 32'h0;
        end
        s_d = s_q;
        if (load) begin
            s_d.ans.cycles = c;
            s_d.ans.not_repeatable = rep_bad;
            s_d.ans.unsupported = unsup;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign ans = s_q.ans;
endmodule // ict_cycle_table
`default_nettype wire

// File: core/ict_timing.sv
/*
 instruction cycle timing top: derives p, d and i waits, holds the repeat count
 and answers each timing request one cycle after it is taken.
 assumes the requester holds access times steady and issues one request at a time.
*/
// Contract
// - program waits zero within limit, else smallest k covering access time
// - machine period equals four crystal clock periods
// - data waits use the same threshold rule
// - io waits use the same threshold rule
// - load class counts 1, 2+d, 1+p, 2+d+p by location
// - store class counts 1, 1+d, 1+p, 2+d+p by location
// - port read counts 2+i, 2+d+i, 2+p+i, 3+d+p+i
// - port write counts 1+i, 2+d+i, 2+p+i, 3+d+p+i
// - repeated load counts n, 1+n+nd, n+p, 1+n+nd+p
// - repeated port read counts 1+n+ni, 2n+nd+ni, 1+n+p+ni
// - long immediate instructions cannot be repeated
// - conditional branches cannot be repeated
// - unconditional branch, call, return, trap cannot be repeated
// - table write into rom is unsupported
// - repeat count n comes from repeat-next or repeat-immediate
`timescale 1ns/100ps
`default_nettype none
module ict_timing
    import ict_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [15:0] xtal_period_ns,
    input wire logic [15:0] t_ac_ns,
    input wire logic [15:0] t_prog_mem_ns,
    input wire logic [15:0] t_data_mem_ns,
    input wire logic [15:0] t_io_mem_ns,
    input wire logic repeat_next_op,
    input wire logic repeat_immediate_op,
    input wire logic [15:0] repeat_count,
    input wire logic req_valid,
    input wire ict_req_t req,
    output logic ans_valid,
    output ict_ans_t ans,
    output logic [3:0] prog_waits,
    output logic [3:0] data_waits,
    output logic [3:0] io_waits
);
    typedef struct packed {
        ict_state_t st;
        logic [15:0] rep_n;
        logic [15:0] machine_ns;
    } ict_top_state_t;

    ict_top_state_t s_q, s_d;
    ict_req_t req_eff;
    logic take;

    // requests are taken only while idle, so one answer per request
    assign take = req_valid && (s_q.st == ICT_ST_IDLE);

    // machine period, repeat count capture and answer sequencing
    always_comb begin
        s_d = s_q;
        s_d.machine_ns = 16'(xtal_period_ns * 16'(XTAL_PER_MACHINE));
        if (repeat_next_op || repeat_immediate_op) begin
            s_d.rep_n = repeat_count;
        end
        case (s_q.st)
            ICT_ST_IDLE: begin
                if (take) begin
                    s_d.st = ICT_ST_DONE;
                end
            end
            ICT_ST_DONE: begin
                s_d.st = ICT_ST_IDLE;
            end
            default: begin
                s_d.st = ICT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.st <= ICT_ST_IDLE;
            s_q.rep_n <= REPEAT_RESET;
            s_q.machine_ns <= 16'h0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // the repeat count of the request is the captured one
    always_comb begin
        req_eff = req;
        req_eff.repeat_n = s_q.rep_n;
    end

    // one threshold rule shared by program, data and io
    ict_wait_calc u_prog (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .t_mem_ns(t_prog_mem_ns),
        .t_ac_ns(t_ac_ns),
        .t_machine_ns(s_q.machine_ns),
        .waits(prog_waits)
    );
    ict_wait_calc u_data (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .t_mem_ns(t_data_mem_ns),
        .t_ac_ns(t_ac_ns),
        .t_machine_ns(s_q.machine_ns),
        .waits(data_waits)
    );
    ict_wait_calc u_io (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .t_mem_ns(t_io_mem_ns),
        .t_ac_ns(t_ac_ns),
        .t_machine_ns(s_q.machine_ns),
        .waits(io_waits)
    );

    ict_cycle_table u_tab (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .load(take && clk_en),
        .req(req_eff),
        .p(prog_waits),
        .d(data_waits),
        .i(io_waits),
        .ans(ans)
    );

    assign ans_valid = (s_q.st == ICT_ST_DONE);

    a_ans_one_cycle: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en) |=> ans_valid)
        else $error("answer did not follow a taken request");
    a_onchip_load: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.cls == ICT_CLS_LOAD && !req.repeat_on
         && req.code_loc != ICT_LOC_EXT && !req.data_ext)
        |=> ans.cycles == 32'h1)
        else $error("on-chip load not one cycle");
    a_store_ext: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.cls == ICT_CLS_STORE && !req.repeat_on
         && req.code_loc != ICT_LOC_EXT && req.data_ext)
        |=> ans.cycles == 32'h1 + 32'($past(data_waits)))
        else $error("store with external data wrong");
    a_port_rd_int: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.cls == ICT_CLS_PORT_RD && !req.repeat_on
         && req.code_loc != ICT_LOC_EXT && !req.data_ext)
        |=> ans.cycles == 32'h2 + 32'($past(io_waits)))
        else $error("port read on chip wrong");
    a_port_wr_int: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.cls == ICT_CLS_PORT_WR
         && req.code_loc != ICT_LOC_EXT && !req.data_ext)
        |=> ans.cycles == 32'h1 + 32'($past(io_waits)))
        else $error("port write on chip wrong");
    a_no_repeat_imm: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.repeat_on && req.cls == ICT_CLS_LONG_IMM)
        |=> ans.not_repeatable)
        else $error("long immediate repeat not refused");
    a_no_repeat_cb: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.repeat_on && req.cls == ICT_CLS_COND_BR)
        |=> ans.not_repeatable)
        else $error("conditional branch repeat not refused");
    a_no_repeat_ub: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.repeat_on && req.cls == ICT_CLS_UNCOND_BR)
        |=> ans.not_repeatable)
        else $error("branch repeat not refused");
    a_table_write_op_rom: assert property (@(posedge clk) disable iff (reset)
        (take && clk_en && req.cls == ICT_CLS_TBL_WR && req.tbl_in_rom)
        |=> ans.unsupported && ans.cycles == 32'h0)
        else $error("rom table write not flagged");
    a_rep_capture: assert property (@(posedge clk) disable iff (reset)
        (clk_en && repeat_immediate_op) |=> s_q.rep_n == $past(repeat_count))
        else $error("repeat count not captured");
    a_machine_x4: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> s_q.machine_ns == 16'($past(xtal_period_ns) * 16'h4))
        else $error("machine period not four crystal periods");
endmodule // ict_timing
`default_nettype wire

// File: tb/ict_ext_mem.sv
/*
 external program, data and i/o memory model: supplies access times in ns.
 assumes the timing block reads the times as steady levels.
*/
`timescale 1ns/100ps
`default_nettype none
module ict_ext_mem (
    input wire logic slow,
    output logic [15:0] t_prog_ns,
    output logic [15:0] t_data_ns,
    output logic [15:0] t_io_ns
);
    // slow parts sit past a threshold, the io part 1 ns past; fast parts sit exactly on the zero-wait limit
    assign t_prog_ns = slow ? 16'h0078 : 16'h0032;
    assign t_data_ns = slow ? 16'h012c : 16'h0032;
    assign t_io_ns = slow ? 16'h0097 : 16'h0032;
endmodule // ict_ext_mem
`default_nettype wire

// File: tb/test_instruction_cycle_timing.sv
/*
 self-checking bench of the instruction cycle timing block.
 assumes the memory model gives p=1, d=3, i=2 when slow and zero waits when fast.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_instruction_cycle_timing
    import ict_pkg::*;
;
    typedef struct {ict_req_t r; ict_ans_t a;} ict_row_t;
    logic clk, reset, clk_en, slow, rn_op, ri_op, req_valid, ans_valid;
    logic [15:0] xtal, tac, rcnt, tp, td, ti;
    logic [3:0] pw, dw, iw;
    ict_req_t req;
    ict_ans_t ans;
    int fails, checks_done, cyc;
    ict_row_t rows[$];

    ict_ext_mem i_ict_ext_mem (.slow(slow), .t_prog_ns(tp), .t_data_ns(td), .t_io_ns(ti));
    ict_timing i_ict_timing (.clk(clk), .reset(reset), .clk_en(clk_en), .xtal_period_ns(xtal),
        .t_ac_ns(tac), .t_prog_mem_ns(tp), .t_data_mem_ns(td), .t_io_mem_ns(ti),
        .repeat_next_op(rn_op), .repeat_immediate_op(ri_op), .repeat_count(rcnt),
        .req_valid(req_valid), .req(req), .ans_valid(ans_valid), .ans(ans),
        .prog_waits(pw), .data_waits(dw), .io_waits(iw));

    task automatic add(ict_cls_t c, ict_loc_t l, int de, int rom, int rp, int cy, int nr, int us);
        ict_row_t w;
        w.r = '{c, l, 1'(de), 1'(rom), 1'(rp), 16'h0000};
        w.a = '{32'(cy), 1'(nr), 1'(us)};
        rows.push_back(w);
    endtask

    // one request, then the answer cycle that follows it
    task automatic send(ict_req_t r);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        `CHK(ans_valid, 1'b1)
    endtask

    task automatic finish_test();
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        reset = 1'b1; clk_en = 1'b1; slow = 1'b1; rn_op = 1'b0; ri_op = 1'b0;
        rcnt = 16'h0005; req_valid = 1'b0; req = '0; xtal = 16'h0019; tac = 16'h0032;
        fails = 0; checks_done = 0; cyc = 0;
        // 25 ns crystal gives a 100 ns machine period
        add(ICT_CLS_LOAD, ICT_LOC_RAM, 0, 0, 0, 8'h01, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_RAM, 1, 0, 0, 8'h05, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_EXT, 0, 0, 0, 8'h02, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_EXT, 1, 0, 0, 8'h06, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_ROM, 1, 0, 0, 8'h05, 0, 0);
        add(ICT_CLS_STORE, ICT_LOC_RAM, 1, 0, 0, 8'h04, 0, 0);
        add(ICT_CLS_STORE, ICT_LOC_EXT, 0, 0, 0, 8'h02, 0, 0);
        add(ICT_CLS_STORE, ICT_LOC_EXT, 1, 0, 0, 8'h06, 0, 0);
        add(ICT_CLS_STORE, ICT_LOC_ROM, 0, 0, 0, 8'h01, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_RAM, 0, 0, 0, 8'h04, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_RAM, 1, 0, 0, 8'h07, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_EXT, 0, 0, 0, 8'h05, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_EXT, 1, 0, 0, 8'h09, 0, 0);
        add(ICT_CLS_PORT_WR, ICT_LOC_ROM, 0, 0, 0, 8'h03, 0, 0);
        add(ICT_CLS_PORT_WR, ICT_LOC_RAM, 1, 0, 0, 8'h07, 0, 0);
        add(ICT_CLS_PORT_WR, ICT_LOC_EXT, 0, 0, 0, 8'h05, 0, 0);
        add(ICT_CLS_PORT_WR, ICT_LOC_EXT, 1, 0, 0, 8'h09, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_RAM, 0, 0, 1, 8'h05, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_RAM, 1, 0, 1, 8'h15, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_EXT, 0, 0, 1, 8'h06, 0, 0);
        add(ICT_CLS_LOAD, ICT_LOC_EXT, 1, 0, 1, 8'h16, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_RAM, 0, 0, 1, 8'h10, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_RAM, 1, 0, 1, 8'h23, 0, 0);
        add(ICT_CLS_PORT_RD, ICT_LOC_EXT, 0, 0, 1, 8'h11, 0, 0);
        add(ICT_CLS_LONG_IMM, ICT_LOC_RAM, 0, 0, 1, 8'h00, 1, 0);
        add(ICT_CLS_COND_BR, ICT_LOC_EXT, 0, 0, 1, 8'h00, 1, 0);
        add(ICT_CLS_UNCOND_BR, ICT_LOC_ROM, 0, 0, 1, 8'h00, 1, 0);
        add(ICT_CLS_TBL_WR, ICT_LOC_ROM, 0, 1, 0, 8'h00, 0, 1);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        #1;
        `CHK(ans, '0)
        `CHK(ans_valid, 1'b0)
        // n is captured from the immediate repeat op
        @(posedge clk);
        ri_op <= 1'b1;
        @(posedge clk);
        ri_op <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK(pw, 4'h1)
        `CHK(dw, 4'h3)
        `CHK(iw, 4'h2)
        foreach (rows[k]) begin
            send(rows[k].r);
            `CHK(ans, rows[k].a)
        end
        // repeat-next op replaces n with 2: 1+n+nd = 9
        @(posedge clk);
        rcnt <= 16'h0002;
        rn_op <= 1'b1;
        @(posedge clk);
        rn_op <= 1'b0;
        send(rows[1].r | ict_req_t'(17'h10000));
        `CHK(ans.cycles, 32'h0000_0009)
        // a request held into the answer cycle is dropped
        @(posedge clk);
        req_valid <= 1'b1;
        req <= rows[0].r;
        @(posedge clk);
        req <= rows[12].r;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        `CHK(ans_valid, 1'b0)
        `CHK(ans, rows[0].a)
        // access time equal to the limit means no waits
        slow <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK({pw, dw, iw}, 12'h000)
        send(rows[12].r);
        `CHK(ans.cycles, 32'h0000_0003)
        // reset in mid-run clears the answer and the waits
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        `CHK(ans, '0)
        `CHK(pw, 4'h0)
        finish_test();
    end
endmodule // test_instruction_cycle_timing
`default_nettype wire
